/* File: include/pmu_pkg.sv */
// Constants, register map and types of the power-mode and clock-gating controller.
// Assumes a single system clock and an AXI4-Lite register port with 32-bit data.
package pmu_pkg;
   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_CLKCFG = 8'h04;
   localparam logic [7:0] OFF_PCLKEN = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   localparam logic [7:0] OFF_DIV0   = 8'h10;
   // ==========================================================
   // Field positions
   localparam int CTRL_PROF_LSB  = 0;
   localparam int CTRL_MODE_LSB  = 2;
   localparam int CFG_SRC_LSB    = 0;
   localparam int CFG_DIV_LSB    = 8;
   localparam int ST_ASLEEP_BIT  = 0;
   localparam int ST_MODE_LSB    = 1;
   localparam int ST_WAKE_BIT    = 3;
   // ==========================================================
   // Reset values and response codes
   localparam logic [1:0] SRC_INTERNAL_RC = 2'h0;
   localparam logic [7:0] CORE_DIV_RESET  = 8'h01;
   localparam logic [1:0] PROFILE_RESET   = 2'h0;
   localparam logic [1:0] RESP_OKAY       = 2'h0;
   localparam logic [1:0] RESP_SLVERR     = 2'h2;
   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      LP_SLEEP,
      LP_DEEP_SLEEP,
      LP_POWER_DOWN,
      LP_DEEP_POWER_DOWN
   } lp_mode_e;
   typedef enum logic [1:0] {
      PROF_DEFAULT,
      PROF_PERFORMANCE,
      PROF_EFFICIENCY,
      PROF_LOW_CURRENT
   } profile_e;
   typedef struct packed {
      logic [1:0] src;
      logic [7:0] div;
   } clk_cfg_s;
endpackage : pmu_pkg

/* File: core/pmu_ctrl.sv */
// Power-mode and clock-gating controller with an AXI4-Lite register port.
// Assumes all inputs synchronous to aclk and a clock-gate latch built in standard cells.
//
// Overview of operation
// R01: Sleep, deep-sleep, power-down, deep power-down modes
// R02: Core clock source and divider programmable
// R03: Per-peripheral clock enable register
// R04: Selected peripherals own programmable clock divider
// R05: Four power profiles, default after reset
// R06: Software using USB keeps default profile
// R07: Sleep entry stops core clock
// R08: Re-enabling core clock alone resumes
// R09: Reset or interrupt ends sleep
// R10: Peripherals clocked in sleep, interrupts wake
// R11: Sleep stops memory and bus clocks
// R12: Start on internal RC after reset, deep wake
// R13: Core gate changes only while clock low
`timescale 1ns/1ps
module pmu_ctrl
   import pmu_pkg::*;
#(
   parameter int NUM_PERIPH = 16,
   parameter int NUM_DIV    = 4,
   parameter int NUM_IRQ    = 8
) (
   // Clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // AXI4-Lite write
   input  wire logic [7:0]            awaddr,
   input  wire logic                  awvalid,
   output logic                       awready,
   input  wire logic [31:0]           wdata,
   input  wire logic [3:0]            wstrb,
   input  wire logic                  wvalid,
   output logic                       wready,
   output logic [1:0]                 bresp,
   output logic                       bvalid,
   input  wire logic                  bready,
   // AXI4-Lite read
   input  wire logic [7:0]            araddr,
   input  wire logic                  arvalid,
   output logic                       arready,
   output logic [31:0]                rdata,
   output logic [1:0]                 rresp,
   output logic                       rvalid,
   input  wire logic                  rready,
   // Core side
   input  wire logic                  sleep_req,
   input  wire logic [NUM_IRQ-1:0]    irq_in,
   output logic                       core_clk,
   output logic                       core_run_ff,
   output logic                       mem_clk_en_ff,
   output logic                       bus_clk_en_ff,
   output lp_mode_e                   lp_mode_ff,
   output profile_e                   profile_ff,
   output clk_cfg_s                   clk_cfg_ff,
   // Peripheral clocks
   output logic [NUM_PERIPH-1:0]      periph_clk_en_ff,
   output logic [NUM_DIV-1:0]         div_tick_ff
);
   // ==========================================================
   // Bus handshake state, wake flag, divider values and power state
   logic        awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic [1:0]  bresp_ff, rresp_ff;
   logic [31:0] rdata_ff;
   logic        wake_irq_ff;
   logic [7:0]  div_val_ff [NUM_DIV];
   lp_mode_e    req_mode_ff;

   typedef enum logic {ST_ACTIVE, ST_ASLEEP} pstate_e;
   pstate_e state_ff, nxt_state;

   assign awready = awready_ff;
   assign wready  = wready_ff;
   assign bvalid  = bvalid_ff;
   assign bresp   = bresp_ff;
   assign arready = arready_ff;
   assign rvalid  = rvalid_ff;
   assign rresp   = rresp_ff;
   assign rdata   = rdata_ff;

   // Address and data are taken together in one cycle; no skid buffer needed
   wire wr_take = awvalid && wvalid && !bvalid_ff && !awready_ff;
   wire wr_fire = awready_ff;
   wire rd_take = arvalid && !rvalid_ff && !arready_ff;

   logic [7:0]  wa_ff;
   logic [31:0] wd_ff;
   logic [3:0]  ws_ff;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // ==========================================================
   // Register images and decode
   wire [31:0] ctrl_img   = {28'h0, req_mode_ff, profile_ff};
   wire [31:0] cfg_img    = {16'h0, clk_cfg_ff.div, 6'h0, clk_cfg_ff.src};
   wire [31:0] pclk_img   = 32'(periph_clk_en_ff);
   wire [31:0] status_img = {28'h0, wake_irq_ff, lp_mode_ff, state_ff == ST_ASLEEP};

   wire wr_ctrl = wr_fire && wa_ff == OFF_CTRL;
   wire wr_cfg  = wr_fire && wa_ff == OFF_CLKCFG;
   wire wr_pclk = wr_fire && wa_ff == OFF_PCLKEN;
   wire [7:0] wr_dix = 8'((wa_ff - OFF_DIV0) >> 2);
   wire wr_div  = wr_fire && wa_ff >= OFF_DIV0 && wa_ff[1:0] == 2'h0 && wr_dix < 8'(NUM_DIV);
   wire wr_ok   = wr_ctrl || wr_cfg || wr_pclk || wr_div || (wa_ff == OFF_STATUS);

   wire [7:0] rd_dix = 8'((araddr - OFF_DIV0) >> 2);
   wire rd_div = araddr >= OFF_DIV0 && araddr[1:0] == 2'h0 && rd_dix < 8'(NUM_DIV);
   wire [31:0] wmerged = merge(ctrl_img, wd_ff, ws_ff);
   wire [31:0] cmerged = merge(cfg_img, wd_ff, ws_ff);
   wire [31:0] pmerged = merge(pclk_img, wd_ff, ws_ff);

   logic [31:0] rd_mux;
   logic        rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      rd_mux = 32'h0;
      case (araddr)
         OFF_CTRL:   rd_mux = ctrl_img;
         OFF_CLKCFG: rd_mux = cfg_img;
         OFF_PCLKEN: rd_mux = pclk_img;
         OFF_STATUS: rd_mux = status_img;
         default: begin
            if (rd_div) begin
               rd_mux = {24'h0, div_val_ff[rd_dix[$clog2(NUM_DIV)-1:0]]};
            end else begin
               rd_hit = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= RESP_OKAY;
         wa_ff      <= 8'h0;
         wd_ff      <= 32'h0;
         ws_ff      <= 4'h0;
      end else begin
         awready_ff <= wr_take;
         wready_ff  <= wr_take;
         if (wr_take) begin
            wa_ff <= awaddr;
            wd_ff <= wdata;
            ws_ff <= wstrb;
         end
         if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0;
         rresp_ff   <= RESP_OKAY;
      end else begin
         arready_ff <= rd_take;
         if (rd_take) begin
            rdata_ff <= rd_mux;
            rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (arready_ff) begin
            rvalid_ff <= 1'b1;
         end else if (rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Power-mode sequencing
   wire any_irq    = |irq_in;
   wire enter_lp   = state_ff == ST_ACTIVE && sleep_req;                    // [R01]
   wire leave_lp   = state_ff == ST_ASLEEP && any_irq;                      // [R09] [R10]
   wire deep_wake  = leave_lp && lp_mode_ff == LP_DEEP_POWER_DOWN;

   always_comb begin
      case (state_ff)
         ST_ACTIVE: nxt_state = enter_lp ? ST_ASLEEP : ST_ACTIVE;
         ST_ASLEEP: nxt_state = leave_lp ? ST_ACTIVE : ST_ASLEEP;
         default:   nxt_state = ST_ACTIVE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff      <= ST_ACTIVE;                                          // [R09]
         core_run_ff   <= 1'b1;
         mem_clk_en_ff <= 1'b1;
         bus_clk_en_ff <= 1'b1;
         lp_mode_ff    <= LP_SLEEP;
         req_mode_ff   <= LP_SLEEP;
         profile_ff    <= PROF_DEFAULT;                                       // [R05]
         wake_irq_ff   <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         // Restoring the enables, plus the clock-config reload on deep power-down wake, is the whole exit path; nothing is sequenced
         core_run_ff   <= nxt_state == ST_ACTIVE;                             // [R07] [R08]
         mem_clk_en_ff <= nxt_state == ST_ACTIVE;                             // [R11]
         bus_clk_en_ff <= nxt_state == ST_ACTIVE;                             // [R11]
         if (enter_lp) begin
            lp_mode_ff <= req_mode_ff;                                        // [R01]
         end
         if (wr_ctrl) begin
            profile_ff  <= profile_e'(wmerged[CTRL_PROF_LSB +: 2]);           // [R05]
            req_mode_ff <= lp_mode_e'(wmerged[CTRL_MODE_LSB +: 2]);
         end
         // Wake flag is set by hardware; entering sleep again clears it
         if (leave_lp) begin
            wake_irq_ff <= 1'b1;
         end else if (enter_lp) begin
            wake_irq_ff <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Clock configuration
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_cfg_ff.src   <= SRC_INTERNAL_RC;                                 // [R12]
         clk_cfg_ff.div   <= CORE_DIV_RESET;
         periph_clk_en_ff <= '0;
      end else begin
         // Deep power-down wake wins over a same-cycle software write
         if (deep_wake) begin
            clk_cfg_ff.src <= SRC_INTERNAL_RC;                                // [R12]
            clk_cfg_ff.div <= CORE_DIV_RESET;
         end else if (wr_cfg) begin
            clk_cfg_ff.src <= cmerged[CFG_SRC_LSB +: 2];                      // [R02]
            clk_cfg_ff.div <= cmerged[CFG_DIV_LSB +: 8];                      // [R02]
         end
         // Peripheral enables are untouched by sleep so they keep running
         if (wr_pclk) begin
            periph_clk_en_ff <= pmerged[NUM_PERIPH-1:0];                      // [R03] [R10]
         end
      end
   end

   // ==========================================================
   // Peripheral dividers: a tick every div cycles, div 0 holds it off
   genvar g;
   generate
      for (g = 0; g < NUM_DIV; g++) begin : g_div
         logic [7:0] cnt_ff;
         wire hit = cnt_ff + 8'h1 >= div_val_ff[g];
         wire [31:0] dmerged = merge({24'h0, div_val_ff[g]}, wd_ff, ws_ff);
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               div_val_ff[g]  <= 8'h0;
               cnt_ff         <= 8'h0;
               div_tick_ff[g] <= 1'b0;
            end else begin
               if (wr_div && wr_dix == 8'(g)) begin
                  div_val_ff[g] <= dmerged[7:0];
               end
               if (!periph_clk_en_ff[g] || div_val_ff[g] == 8'h0 || hit) begin
                  cnt_ff <= 8'h0;
               end else begin
                  cnt_ff <= cnt_ff + 8'h1;
               end
               div_tick_ff[g] <= periph_clk_en_ff[g] && div_val_ff[g] != 8'h0 && hit; // [R04]
            end
         end
      end
   endgenerate

   // ==========================================================
   // Core clock gate: latch is transparent only while aclk is low
   logic gate_lat;
   always_latch begin
      if (!aclk) begin
         gate_lat = core_run_ff;                                              // [R13]
      end
   end
   assign core_clk = aclk & gate_lat;                                         // [R07] [R13]

   // ==========================================================
   // Checks
   a_sleep_stops_core: assert property (@(posedge aclk) disable iff (!aresetn) // [R07]
      enter_lp |=> !core_run_ff) else $error("core clock not stopped on sleep entry");
   a_irq_wakes_core: assert property (@(posedge aclk) disable iff (!aresetn) // [R09]
      leave_lp |=> core_run_ff && state_ff == ST_ACTIVE) else $error("interrupt did not wake core");
   a_asleep_holds: assert property (@(posedge aclk) disable iff (!aresetn) // [R08]
      state_ff == ST_ASLEEP && !any_irq |=> !core_run_ff) else $error("core woke without cause");
   a_mem_bus_gated: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
      mem_clk_en_ff == (state_ff == ST_ACTIVE) && bus_clk_en_ff == (state_ff == ST_ACTIVE))
      else $error("memory or bus clock ungated");
   a_periph_kept: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
      !wr_pclk |=> $stable(periph_clk_en_ff)) else $error("peripheral enables changed without write");
   a_mode_latched: assert property (@(posedge aclk) disable iff (!aresetn) // [R01]
      enter_lp |=> lp_mode_ff == $past(req_mode_ff)) else $error("low-power mode not latched");
   a_deep_wake_rc: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
      deep_wake |=> clk_cfg_ff.src == SRC_INTERNAL_RC) else $error("deep wake not on internal RC");
   a_cfg_write: assert property (@(posedge aclk) disable iff (!aresetn) // [R02]
      wr_cfg && !deep_wake && ws_ff[1] |=> clk_cfg_ff.div == $past(wd_ff[15:8])) else $error("divider not written");
   a_div_tick_off: assert property (@(posedge aclk) disable iff (!aresetn) // [R04]
      !periph_clk_en_ff[0] |=> !div_tick_ff[0]) else $error("divider ticks while disabled");
   a_gate_low: assert property (@(negedge aclk) disable iff (!aresetn) // [R13]
      gate_lat == $past(core_run_ff)) else $error("clock gate changed while clock high");
   a_prof_reset: assert property (@(posedge aclk) // [R05]
      !aresetn |=> profile_ff == PROF_DEFAULT) else $error("profile not default after reset");

endmodule : pmu_ctrl

/* File: tb/core_irq_model.sv */
// Behavioural stand-in for the processor core and the peripheral interrupt sources.
// Assumes the bench sets the want_* controls just after a rising edge of aclk.
`timescale 1ns/1ps
module core_irq_model
#(
   parameter int NUM_IRQ = 8
) (
   // Clock and reset
   input  wire logic               aclk,
   input  wire logic               aresetn,
   // Bench controls and the controller's core run flag
   input  wire logic               want_sleep,
   input  wire logic [NUM_IRQ-1:0] want_irq,
   input  wire logic               core_run_ff,
   // Toward the controller
   output logic                    sleep_req,
   output logic [NUM_IRQ-1:0]      irq_in
);
   // ==========================================================
   // Core side
   // A halted core cannot keep its request up, so it drops once its clock stops
   always_ff @(posedge aclk) begin
      sleep_req <= aresetn && want_sleep && core_run_ff;
      irq_in    <= aresetn ? want_irq : '0;
   end
endmodule : core_irq_model

/* File: tb/test_power_mode_and_clock_gating.sv */
// Self-checking bench of the power-mode and clock-gating controller.
// Assumes the core and interrupt model beside it and an AXI4-Lite master built from tasks.
`timescale 1ns/1ps
module test_power_mode_and_clock_gating
   import pmu_pkg::*;
;
   logic        aclk, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, want_sleep = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, want_irq = 8'h00, irq_in;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0]  wstrb = 4'hf, div_tick_ff;
   logic        awready, wready, bvalid, arready, rvalid, sleep_req;
   logic [1:0]  bresp, rresp;
   logic        core_clk, core_run_ff, mem_clk_en_ff, bus_clk_en_ff;
   lp_mode_e    lp_mode_ff;
   profile_e    profile_ff;
   clk_cfg_s    clk_cfg_ff;
   logic [15:0] periph_clk_en_ff;
   int          errors = 0, cmp_count = 0;
   // ==========================================================
   // Instances
   pmu_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .sleep_req(sleep_req), .irq_in(irq_in), .core_clk(core_clk),
      .core_run_ff(core_run_ff), .mem_clk_en_ff(mem_clk_en_ff), .bus_clk_en_ff(bus_clk_en_ff),
      .lp_mode_ff(lp_mode_ff), .profile_ff(profile_ff), .clk_cfg_ff(clk_cfg_ff),
      .periph_clk_en_ff(periph_clk_en_ff), .div_tick_ff(div_tick_ff));
   core_irq_model i_core (.aclk(aclk), .aresetn(aresetn), .want_sleep(want_sleep), .want_irq(want_irq),
      .core_run_ff(core_run_ff), .sleep_req(sleep_req), .irq_in(irq_in));
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   // ==========================================================
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_hs, w_hs, b_hs;
      int   n;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         #1;
         aw_hs = awready;
         w_hs  = wready;
         b_hs  = bvalid;
         r     = bresp;
         @(posedge aclk);
         if (aw_hs) awvalid <= 1'b0;
         if (w_hs) wvalid <= 1'b0;
         if (b_hs) break;
      end
      bready <= 1'b0;
      if (n == 50) check(1'b0, 1'b1);
      #1;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_hs, r_hs;
      int   n;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         #1;
         ar_hs = arready;
         r_hs  = rvalid;
         d     = rdata;
         r     = rresp;
         @(posedge aclk);
         if (ar_hs) arvalid <= 1'b0;
         if (r_hs) break;
      end
      rready <= 1'b0;
      if (n == 50) check(1'b0, 1'b1);
      #1;
   endtask : axi_rd
   // Waits a bounded time for the core run flag to reach the wanted level
   task automatic wait_run(input logic lvl);
      for (int n = 0; n < 20 && core_run_ff !== lvl; n++) begin
         @(posedge aclk);
         #1;
      end
   endtask : wait_run
   task automatic go_sleep(input logic [1:0] mode);
      logic [1:0] r;
      axi_wr(OFF_CLKCFG, 32'h0000_0302, r);
      axi_wr(OFF_CTRL, {28'h0, mode, 2'h0}, r);
      want_sleep <= 1'b1;
      wait_run(1'b0);
      want_sleep <= 1'b0;
      check(core_run_ff, 1'b0);
   endtask : go_sleep
   // ==========================================================
   // Scenarios
   task automatic t_reset_values;
      logic [31:0] d;
      logic [1:0]  r;
      check(32'(clk_cfg_ff), {22'h0, SRC_INTERNAL_RC, CORE_DIV_RESET});
      check(32'(profile_ff), 32'(PROFILE_RESET));
      check(core_clk, 1'b1);
      axi_rd(OFF_CLKCFG, d, r);
      check(d, {16'h0, CORE_DIV_RESET, 6'h0, SRC_INTERNAL_RC});
      axi_rd(OFF_PCLKEN, d, r);
      check(d, 32'h0);
      $display("test reset values done");
   endtask : t_reset_values
   task automatic t_registers;
      logic [31:0] d;
      logic [1:0]  r;
      for (int p = 0; p < 4; p++) begin
         axi_wr(OFF_CTRL, 32'(p), r);
         check(32'(profile_ff), 32'(p));
      end
      axi_wr(OFF_CTRL, 32'h0, r);
      axi_wr(OFF_CLKCFG, 32'h0000_0702, r);
      check(32'(clk_cfg_ff), 32'h0000_0207);
      wstrb <= 4'h2;
      axi_wr(OFF_CLKCFG, 32'hffff_ffff, r);
      wstrb <= 4'hf;
      check(32'(clk_cfg_ff), 32'h0000_02ff);
      axi_wr(8'h40, 32'hffff_ffff, r);
      check(r, RESP_SLVERR);
      axi_rd(8'h40, d, r);
      check(r, RESP_SLVERR);
      check(d, 32'h0);
      $display("test registers done");
   endtask : t_registers
   task automatic t_dividers;
      logic [1:0] r;
      int         c0 = 0, c1 = 0, c2 = 0;
      axi_wr(OFF_PCLKEN, 32'h0000_0003, r);
      axi_wr(OFF_DIV0, 32'h3, r);
      axi_wr(OFF_DIV0 + 8'h04, 32'h1, r);
      axi_wr(OFF_DIV0 + 8'h08, 32'h5, r);
      check(periph_clk_en_ff, 16'h0003);
      repeat (4) @(posedge aclk);
      repeat (30) begin
         @(posedge aclk);
         #1;
         c0 += div_tick_ff[0];
         c1 += div_tick_ff[1];
         c2 += div_tick_ff[2];
      end
      check(c0, 10);
      check(c1, 30);
      check(c2, 0);
      $display("test dividers done");
   endtask : t_dividers
   task automatic t_sleep(input logic [1:0] mode);
      logic [31:0] d;
      logic [1:0]  r;
      int          c = 0;
      go_sleep(mode);
      check(32'(lp_mode_ff), 32'(mode));
      check({mem_clk_en_ff, bus_clk_en_ff}, 2'b00);
      repeat (6) begin
         @(posedge aclk);
         #1;
         check(core_clk, 1'b0);
         c += div_tick_ff[1];
      end
      check(c, 6);
      axi_rd(OFF_STATUS, d, r);
      check(d[3:0], {1'b0, mode, 1'b1});
      want_irq <= 8'h80 >> mode;
      wait_run(1'b1);
      want_irq <= 8'h00;
      check({core_run_ff, mem_clk_en_ff, bus_clk_en_ff}, 3'b111);
      @(posedge aclk);
      #1;
      check(core_clk, 1'b1);
      axi_rd(OFF_STATUS, d, r);
      check(d[ST_WAKE_BIT], 1'b1);
      check(32'(clk_cfg_ff), (mode == 2'h3) ? 32'h0000_0001 : 32'h0000_0203);
      $display("test sleep mode %0d done", mode);
   endtask : t_sleep
   task automatic t_reset_wake;
      go_sleep(2'h0);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      #1;
      check(core_run_ff, 1'b1);
      check(32'(clk_cfg_ff), 32'h0000_0001);
      @(posedge aclk);
      aresetn <= 1'b1;
      $display("test reset wake done");
   endtask : t_reset_wake
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish
   // ==========================================================
   // Gated clock is low with aclk; its high phase follows the run flag held in the low phase before
   logic run_low = 1'b1;
   always @(negedge aclk) begin
      #1;
      run_low = core_run_ff;
      if (aresetn) check(core_clk, 1'b0);
   end
   always @(posedge aclk) begin
      #1;
      if (aresetn) check(core_clk, run_low);
   end
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      #1;
      t_reset_values();
      t_registers();
      t_dividers();
      for (int m = 0; m < 4; m++) t_sleep(2'(m));
      t_reset_wake();
      tally_and_finish();
   end
   initial begin
      repeat (20000) @(posedge aclk);
      errors++;
      tally_and_finish();
   end
endmodule : test_power_mode_and_clock_gating
